/* hw/sfr_pkg.sv */
package sfr_pkg;
	// array geometry
	localparam int ADDR_W    = 15;
	localparam int MEM_DEPTH = 32768;

	// opcodes
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_WRSR  = 8'h01;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_FSTRD = 8'h0b;
	localparam logic [7:0] OP_WRITE = 8'h02;

	// status byte layout
	localparam int SR_PEN_BIT = 7;
	localparam int SR_BP_HI   = 3;
	localparam int SR_BP_LO   = 2;
	localparam int SR_WEL_BIT = 1;
	localparam logic [7:0] SR_RESET = 8'h00;

	// link timing on the host side
	localparam int SYS_CLK_MHZ  = 100;
	localparam int SCK_HALF_NS  = 40;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

	typedef enum logic [7:0] {
		D_OPC = 8'h01,
		D_ADR = 8'h02,
		D_DUM = 8'h04,
		D_RDA = 8'h08,
		D_WDA = 8'h10,
		D_SRD = 8'h20,
		D_SWR = 8'h40,
		D_IGN = 8'h80
	} sfr_dev_state_t;

	typedef enum logic [6:0] {
		M_IDLE  = 7'h01,
		M_SETUP = 7'h02,
		M_LOW   = 7'h04,
		M_HIGH  = 7'h08,
		M_PAUSE = 7'h10,
		M_END   = 7'h20,
		M_GAP   = 7'h40
	} sfr_host_state_t;
endpackage

/* hw/sfr_link_if.sv */
`timescale 1ns/10ps
interface sfr_link_if;
	logic sck;
	logic csN;
	logic mosi;
	logic holdN;
	logic wpN;
	logic misoO;
	logic misoOe;
	logic misoLine;

	// undriven data line is seen high
	assign misoLine = misoOe ? misoO : 1'b1;

	modport dev (input sck, csN, mosi, holdN, wpN, output misoO, misoOe);
	modport host (output sck, csN, mosi, holdN, wpN, input misoLine);
endinterface

/* hw/sfr_sync2.sv */
`timescale 1ns/10ps
module sfr_sync2 (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// level
	input  wire logic din,
	output logic      dout
);
	logic meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // sfr_sync2

/* hw/sfr_device.sv */
// Functional notes
// [R1] select high: standby, inputs ignored, output off
// [R2] select low enables serial clock response
// [R3] master gives fresh select fall per opcode
// [R4] sample rising edge, drive falling edge
// [R5] fully static, clock may stop anytime
// [R6] output driven only for read data
// [R7] pin protect blocks status write
// [R8] pause low freezes clock and select
// [R9] master changes pause only clock low
// [R10] fifteen address bits, top bit ignored
// [R11] two address bytes follow opcode
// [R12] first byte opcode, then address, data
// [R13] each byte written at bus speed
// [R14] modes 0 and 3, first rise samples
// [R15] master initiates and clocks everything
// [R16] most significant bit first
// [R17] clock level at select fall picks mode
// [R18] unknown opcode ignored until next select
// [R19] pause resumes at same bit position
// [R20] partial byte dropped at select rise
`timescale 1ns/10ps
module sfr_device (
	// serial link
	sfr_link_if.dev    link,
	// power-up reset
	input  wire logic  rst,
	// observation
	output logic       modeThree,
	output logic [7:0] statusView
);
	logic [7:0]                 mem [sfr_pkg::MEM_DEPTH];
	sfr_pkg::sfr_dev_state_t    state_q;
	logic [2:0]                 bitCnt_q;
	logic                       byteCnt_q;
	logic [7:0]                 rx_q;
	logic [7:0]                 op_q;
	logic [sfr_pkg::ADDR_W-1:0] addr_q;
	logic [7:0]                 tx_q;
	logic                       welSet_q;
	logic                       welClr_q;
	logic                       wel_q;
	logic                       pen_q;
	logic [1:0]                 bp_q;
	logic                       modeThree_q;
	logic                       so_q;
	logic                       drive_q;
	logic                       frameClr;
	logic [7:0]                 rxNext;
	logic                       byteDone;
	logic [sfr_pkg::ADDR_W-1:0] addrFull;
	logic [7:0]                 statusByte;
	logic                       srWriteOk;
	logic                       blocked;

	// select high (unless paused) clears all framing state
	assign frameClr = rst | (link.csN & link.holdN); // [R1] [R2] [R20] [R8]
	assign rxNext   = {rx_q[6:0], link.mosi}; // [R16]
	assign byteDone = (bitCnt_q == 3'h7);
	assign addrFull = {addr_q[6:0], rxNext}; // [R10]

	assign statusByte = {pen_q, 3'h0, bp_q, wel_q, 1'b0};

	// pin protect only bites when the enable bit is set
	assign srWriteOk = wel_q & ~(pen_q & ~link.wpN); // [R7]

	// block protect: upper quarter, upper half, or whole array
	always_comb begin
		case (bp_q)
			2'h1: blocked = (addr_q[14:13] == 2'h3);
			2'h2: blocked = addr_q[14];
			2'h3: blocked = 1'b1;
			default: blocked = 1'b0;
		endcase
	end

	// framing: all input taken on rising edges only
	always_ff @(posedge link.sck or posedge frameClr) begin // [R4] [R14]
		if (frameClr) begin
			state_q   <= sfr_pkg::D_OPC;
			bitCnt_q  <= 3'h0;
			byteCnt_q <= 1'b0;
			rx_q      <= 8'h00;
			op_q      <= 8'h00;
			addr_q    <= '0;
			tx_q      <= 8'h00;
		end else if (link.holdN) begin // [R8] [R19]
			rx_q     <= rxNext;
			bitCnt_q <= bitCnt_q + 3'h1;
			if (byteDone) begin
				case (state_q)
					sfr_pkg::D_OPC: begin // [R12]
						op_q <= rxNext;
						case (rxNext)
							sfr_pkg::OP_RDSR: begin
								state_q <= sfr_pkg::D_SRD;
								tx_q    <= statusByte;
							end
							sfr_pkg::OP_WRSR: begin
								state_q <= sfr_pkg::D_SWR;
							end
							sfr_pkg::OP_READ,
							sfr_pkg::OP_FSTRD,
							sfr_pkg::OP_WRITE: begin
								state_q <= sfr_pkg::D_ADR; // [R11]
							end
							default: begin
								// write-latch opcodes and unknown ones end here
								state_q <= sfr_pkg::D_IGN; // [R18]
							end
						endcase
					end
					sfr_pkg::D_ADR: begin
						byteCnt_q <= 1'b1;
						addr_q    <= addrFull; // [R10]
						if (byteCnt_q) begin // [R11]
							case (op_q)
								sfr_pkg::OP_READ: begin
									state_q <= sfr_pkg::D_RDA;
									tx_q    <= mem[addrFull];
									addr_q  <= addrFull + 15'h1;
								end
								sfr_pkg::OP_FSTRD: begin
									state_q <= sfr_pkg::D_DUM;
								end
								default: begin
									state_q <= sfr_pkg::D_WDA;
								end
							endcase
						end
					end
					sfr_pkg::D_DUM: begin
						state_q <= sfr_pkg::D_RDA;
						tx_q    <= mem[addr_q];
						addr_q  <= addr_q + 15'h1;
					end
					sfr_pkg::D_RDA: begin
						tx_q   <= mem[addr_q];
						addr_q <= addr_q + 15'h1;
					end
					sfr_pkg::D_WDA: begin
						addr_q <= addr_q + 15'h1;
					end
					sfr_pkg::D_SRD: begin
						tx_q <= statusByte;
					end
					sfr_pkg::D_SWR: begin
						state_q <= sfr_pkg::D_IGN;
					end
					default: begin
						state_q <= sfr_pkg::D_IGN;
					end
				endcase
			end
		end
	end

	// array commit on the eighth bit, no busy time
	always_ff @(posedge link.sck) begin
		if (link.holdN && !link.csN && state_q == sfr_pkg::D_WDA && byteDone &&
				wel_q && !blocked) begin
			mem[addr_q] <= rxNext; // [R13] [R20]
		end
	end

	// persistent status bits
	always_ff @(posedge link.sck or posedge rst) begin
		if (rst) begin
			pen_q <= sfr_pkg::SR_RESET[sfr_pkg::SR_PEN_BIT];
			bp_q  <= sfr_pkg::SR_RESET[sfr_pkg::SR_BP_HI:sfr_pkg::SR_BP_LO];
		end else if (link.holdN && !link.csN && state_q == sfr_pkg::D_SWR &&
				byteDone && srWriteOk) begin // [R7]
			pen_q <= rxNext[sfr_pkg::SR_PEN_BIT];
			bp_q  <= rxNext[sfr_pkg::SR_BP_HI:sfr_pkg::SR_BP_LO];
		end
	end

	// per-frame latch requests, cleared on the first bit of a new frame
	always_ff @(posedge link.sck or posedge rst) begin
		if (rst) begin
			welSet_q <= 1'b0;
			welClr_q <= 1'b0;
		end else if (link.holdN && !link.csN) begin
			if (state_q == sfr_pkg::D_OPC && bitCnt_q == 3'h0) begin
				welSet_q <= 1'b0;
				welClr_q <= 1'b0;
			end else if (state_q == sfr_pkg::D_OPC && byteDone) begin
				welSet_q <= (rxNext == sfr_pkg::OP_WREN);
				welClr_q <= (rxNext == sfr_pkg::OP_WRDI) ||
					(rxNext == sfr_pkg::OP_WRSR) ||
					(rxNext == sfr_pkg::OP_WRITE);
			end
		end
	end

	// write latch changes only when select rises; sck is idle then
	always_ff @(posedge link.csN or posedge rst) begin
		if (rst) begin
			wel_q <= sfr_pkg::SR_RESET[sfr_pkg::SR_WEL_BIT];
		end else if (welSet_q) begin
			wel_q <= 1'b1;
		end else if (welClr_q) begin
			wel_q <= 1'b0;
		end
	end

	// clock level at select fall picks the mode
	always_ff @(negedge link.csN or posedge rst) begin
		if (rst) begin
			modeThree_q <= 1'b0;
		end else begin
			modeThree_q <= link.sck; // [R17] [R14]
		end
	end

	// output changes on falling edges, only for read data
	always_ff @(negedge link.sck or posedge frameClr) begin // [R4] [R5]
		if (frameClr) begin
			so_q    <= 1'b0;
			drive_q <= 1'b0;
		end else if (link.holdN) begin
			drive_q <= (state_q == sfr_pkg::D_RDA) || (state_q == sfr_pkg::D_SRD); // [R6]
			so_q    <= tx_q[3'h7 - bitCnt_q]; // [R16]
		end
	end

	// pause releases the line at once
	assign link.misoO  = so_q;
	assign link.misoOe = drive_q & link.holdN; // [R6] [R1]

	assign modeThree  = modeThree_q;
	assign statusView = {pen_q, 3'h0, bp_q, wel_q, 1'b0};
endmodule // sfr_device

/* hw/sfr_host.sv */
`timescale 1ns/10ps
module sfr_host (
	// clock and reset
	input  wire logic  sysClk,
	input  wire logic  rst,
	// serial link
	sfr_link_if.host   link,
	// request
	input  wire logic  reqValid,
	output logic       reqReady,
	input  wire logic  reqModeThree,
	input  wire logic [7:0]  reqOpcode,
	input  wire logic        reqHasAddr,
	input  wire logic [15:0] reqAddr,
	input  wire logic [7:0]  reqLen,
	// write data
	input  wire logic [7:0]  wrData,
	output logic             wrTake,
	// read data
	output logic             rdValid,
	output logic [7:0]       rdData,
	// pins
	input  wire logic        pauseReq,
	input  wire logic        protectLow
);
	sfr_pkg::sfr_host_state_t state_q;
	logic [3:0]  div_q;
	logic [11:0] bitsLeft_q;
	logic [2:0]  bitIn_q;
	logic [8:0]  byteIdx_q;
	logic [8:0]  hdr_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic [15:0] addr_q;
	logic        hasAddr_q;
	logic        mode_q;
	logic        sck_q;
	logic        csN_q;
	logic        mosi_q;
	logic        holdN_q;
	logic        wpN_q;
	logic        ready_q;
	logic        wrTake_q;
	logic        rdValid_q;
	logic [7:0]  rdData_q;
	logic        misoS;
	logic        accept;
	logic        lowEnter;
	logic        riseEv;
	logic [8:0]  nextIdx;

	sfr_sync2 u_miso (
		.clk  (sysClk),
		.rst  (rst),
		.din  (link.misoLine),
		.dout (misoS)
	);

	// select may only fall once the clock already rests at the requested idle level
	assign accept   = (state_q == sfr_pkg::M_IDLE) && reqValid && ready_q &&
		(sck_q == reqModeThree); // [R15] [R17]
	assign lowEnter = (div_q == 4'h0) && ((state_q == sfr_pkg::M_SETUP) ||
		((state_q == sfr_pkg::M_HIGH) && (bitsLeft_q != 12'h0)));
	assign riseEv   = (state_q == sfr_pkg::M_LOW) && (div_q == 4'h0) && !pauseReq;
	assign nextIdx  = byteIdx_q + 9'h1;

	// link sequencing
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			state_q <= sfr_pkg::M_IDLE;
			div_q   <= 4'h0;
			sck_q   <= 1'b0;
			csN_q   <= 1'b1;
			holdN_q <= 1'b1;
			ready_q <= 1'b1;
		end else begin
			if (div_q != 4'h0) begin
				div_q <= div_q - 4'h1;
			end
			case (state_q)
				sfr_pkg::M_IDLE: begin
					sck_q <= reqModeThree;
					if (accept) begin
						csN_q   <= 1'b0; // [R3] [R15]
						ready_q <= 1'b0;
						div_q   <= sfr_pkg::HALF_LAST;
						state_q <= sfr_pkg::M_SETUP;
					end
				end
				sfr_pkg::M_SETUP: begin
					if (div_q == 4'h0) begin
						sck_q   <= 1'b0;
						div_q   <= sfr_pkg::HALF_LAST;
						state_q <= sfr_pkg::M_LOW;
					end
				end
				sfr_pkg::M_LOW: begin
					if (div_q == 4'h0) begin
						if (pauseReq) begin
							holdN_q <= 1'b0; // [R9]
							state_q <= sfr_pkg::M_PAUSE;
						end else begin
							sck_q   <= 1'b1;
							div_q   <= sfr_pkg::HALF_LAST;
							state_q <= sfr_pkg::M_HIGH;
						end
					end
				end
				sfr_pkg::M_PAUSE: begin
					if (!pauseReq) begin
						holdN_q <= 1'b1; // [R9]
						div_q   <= sfr_pkg::HALF_LAST;
						state_q <= sfr_pkg::M_LOW;
					end
				end
				sfr_pkg::M_HIGH: begin
					if (div_q == 4'h0) begin
						div_q <= sfr_pkg::HALF_LAST;
						if (bitsLeft_q == 12'h0) begin
							sck_q   <= mode_q;
							state_q <= sfr_pkg::M_END;
						end else begin
							sck_q   <= 1'b0;
							state_q <= sfr_pkg::M_LOW;
						end
					end
				end
				sfr_pkg::M_END: begin
					if (div_q == 4'h0) begin
						csN_q   <= 1'b1; // [R3]
						div_q   <= sfr_pkg::HALF_LAST;
						state_q <= sfr_pkg::M_GAP;
					end
				end
				sfr_pkg::M_GAP: begin
					if (div_q == 4'h0) begin
						ready_q <= 1'b1;
						state_q <= sfr_pkg::M_IDLE;
					end
				end
				default: begin
					state_q <= sfr_pkg::M_IDLE;
				end
			endcase
		end
	end

	// shift data
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			bitsLeft_q <= 12'h0;
			bitIn_q    <= 3'h0;
			byteIdx_q  <= 9'h0;
			hdr_q      <= 9'h1;
			tx_q       <= 8'h00;
			rx_q       <= 8'h00;
			addr_q     <= 16'h0000;
			hasAddr_q  <= 1'b0;
			mode_q     <= 1'b0;
			mosi_q     <= 1'b0;
			wrTake_q   <= 1'b0;
			rdValid_q  <= 1'b0;
			rdData_q   <= 8'h00;
		end else begin
			wrTake_q  <= 1'b0;
			rdValid_q <= 1'b0;
			if (accept) begin
				// opcode, optional two address bytes, then data
				bitsLeft_q <= {(reqHasAddr ? 9'h3 : 9'h1) + {1'b0, reqLen}, 3'h0}; // [R11] [R12]
				hdr_q      <= reqHasAddr ? 9'h3 : 9'h1;
				bitIn_q    <= 3'h0;
				byteIdx_q  <= 9'h0;
				tx_q       <= reqOpcode;
				addr_q     <= reqAddr;
				hasAddr_q  <= reqHasAddr;
				mode_q     <= reqModeThree;
			end
			if (lowEnter) begin
				mosi_q <= tx_q[7]; // [R16]
				tx_q   <= {tx_q[6:0], 1'b0};
			end
			if (riseEv) begin
				rx_q       <= {rx_q[6:0], misoS};
				bitIn_q    <= bitIn_q + 3'h1;
				bitsLeft_q <= bitsLeft_q - 12'h1;
				if (bitIn_q == 3'h7) begin
					byteIdx_q <= nextIdx;
					if (byteIdx_q >= hdr_q) begin
						rdValid_q <= 1'b1;
						rdData_q  <= {rx_q[6:0], misoS};
					end
					if (hasAddr_q && nextIdx == 9'h1) begin
						tx_q <= addr_q[15:8];
					end else if (hasAddr_q && nextIdx == 9'h2) begin
						tx_q <= addr_q[7:0];
					end else begin
						tx_q     <= wrData;
						wrTake_q <= 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge sysClk or posedge rst) begin
		if (rst) begin
			wpN_q <= 1'b1;
		end else begin
			wpN_q <= ~protectLow;
		end
	end

	assign link.sck   = sck_q;
	assign link.csN   = csN_q;
	assign link.mosi  = mosi_q;
	assign link.holdN = holdN_q;
	assign link.wpN   = wpN_q;
	assign reqReady   = ready_q;
	assign wrTake     = wrTake_q;
	assign rdValid    = rdValid_q;
	assign rdData     = rdData_q;
endmodule // sfr_host

/* dv/sfr_link_props.sv */
`timescale 1ns/10ps
module sfr_link_props (
	// clock and reset
	input wire logic sysClk,
	input wire logic rst,
	// link
	input wire logic sck,
	input wire logic csN,
	input wire logic mosi,
	input wire logic holdN,
	input wire logic wpN,
	input wire logic misoO,
	input wire logic misoOe,
	input wire logic misoLine
);
	logic       sckQ;
	logic [7:0] riseCntQ;

	default clocking cb @(posedge sysClk);
	endclocking
	default disable iff (rst);

	always_ff @(posedge sysClk or posedge rst) begin
		if (rst)
			sckQ <= 1'b0;
		else
			sckQ <= sck;
	end

	// serial clock rises within the current selection
	always_ff @(posedge sysClk or posedge rst) begin
		if (rst)
			riseCntQ <= 8'h00;
		else if (csN)
			riseCntQ <= 8'h00;
		else if (sck && !sckQ)
			riseCntQ <= riseCntQ + 8'h01;
	end

	sequence frameOpen;
		$fell(csN);
	endsequence
	sequence frameClose;
		$rose(csN);
	endsequence
	sequence driveStart;
		$rose(misoOe) && holdN && $past(holdN);
	endsequence

	standby_off_a: assert property (csN |-> !misoOe)
		else $error("miso driven while deselected");
	hold_off_a: assert property (!holdN |-> !misoOe)
		else $error("miso driven while paused");
	out_on_fall_a: assert property (
		misoOe && $past(misoOe) && $changed(misoO) |-> $fell(sck))
		else $error("miso changed away from a falling clock");
	drive_start_a: assert property (driveStart |-> $fell(sck) && riseCntQ >= 8'h08)
		else $error("miso enabled before a whole opcode");
	hold_sck_low_a: assert property ($changed(holdN) |-> !sck && $stable(sck))
		else $error("pause changed while clock high");
	pause_still_a: assert property (
		!holdN && !$past(holdN) |-> $stable(sck) && $stable(csN))
		else $error("link moved during pause");
	gap_a: assert property (frameClose |-> csN[*4])
		else $error("select gap too short");
	setup_a: assert property (frameOpen |=> $stable(sck)[*3])
		else $error("clock moved right after select");
	whole_byte_a: assert property (frameClose |-> riseCntQ[2:0] == 3'h0)
		else $error("frame ended mid byte");
endmodule // sfr_link_props

/* dv/spi_fram_slave_front_end_tb_top.sv */
`timescale 1ns/10ps
module spi_fram_slave_front_end_tb_top;
	logic        sysClk;
	logic        rst;
	logic        reqValid;
	logic        reqReady;
	logic        reqModeThree;
	logic [7:0]  reqOpcode;
	logic        reqHasAddr;
	logic [15:0] reqAddr;
	logic [7:0]  reqLen;
	logic [7:0]  wrData;
	logic        wrTake;
	logic        rdValid;
	logic [7:0]  rdData;
	logic        pauseReq;
	logic        protectLow;
	logic        modeThree;
	logic [7:0]  statusView;
	logic [7:0]  wBuf [8];
	logic [7:0]  rBuf [8];
	int          errors;
	int          checkCount;

	sfr_link_if i_sfr_link_if ();
	sfr_device i_sfr_device (.link(i_sfr_link_if), .rst(rst), .modeThree(modeThree),
		.statusView(statusView));
	sfr_host i_sfr_host (.sysClk(sysClk), .rst(rst), .link(i_sfr_link_if),
		.reqValid(reqValid), .reqReady(reqReady), .reqModeThree(reqModeThree),
		.reqOpcode(reqOpcode), .reqHasAddr(reqHasAddr), .reqAddr(reqAddr),
		.reqLen(reqLen), .wrData(wrData), .wrTake(wrTake), .rdValid(rdValid),
		.rdData(rdData), .pauseReq(pauseReq), .protectLow(protectLow));
	sfr_link_props i_sfr_link_props (.sysClk(sysClk), .rst(rst),
		.sck(i_sfr_link_if.sck), .csN(i_sfr_link_if.csN), .mosi(i_sfr_link_if.mosi),
		.holdN(i_sfr_link_if.holdN), .wpN(i_sfr_link_if.wpN),
		.misoO(i_sfr_link_if.misoO), .misoOe(i_sfr_link_if.misoOe),
		.misoLine(i_sfr_link_if.misoLine));

	initial begin
		sysClk = 1'b0;
		forever #5 sysClk = ~sysClk;
	end

	function automatic logic [7:0] pat(input int i);
		return 8'(8'h1d * (i + 1));
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang(input string what);
		errors++;
		$display("BAD %s expected done seen timeout", what);
		finish_test();
	endtask

	task automatic tick();
		@(posedge sysClk);
		#1;
	endtask

	// one whole frame; pause requested pauseAt cycles in, for 60 cycles
	task automatic xfer(input logic m3, input logic [7:0] op, input logic ha,
		input logic [15:0] a, input logic [7:0] len, input int pauseAt);
		int n;
		int wi;
		int ri;
		n = 0;
		wi = 0;
		ri = 0;
		// stale bytes from an earlier frame must not satisfy a check
		for (int i = 0; i < 8; i++)
			rBuf[i] = 8'hxx;
		while (reqReady !== 1'b1) begin
			tick();
			n++;
			if (n > 1000)
				hang("ready");
		end
		n = 0;
		reqModeThree = m3;
		reqOpcode = op;
		reqHasAddr = ha;
		reqAddr = a;
		reqLen = len;
		wrData = wBuf[0];
		// let the clock settle at its idle level before select falls
		tick();
		reqValid = 1'b1;
		tick();
		reqValid = 1'b0;
		while (reqReady !== 1'b1) begin
			if (n == pauseAt)
				pauseReq = 1'b1;
			if (n == pauseAt + 60)
				pauseReq = 1'b0;
			tick();
			n++;
			if (wrTake === 1'b1) begin
				wi++;
				wrData = wBuf[wi % 8];
			end
			if (rdValid === 1'b1) begin
				rBuf[ri % 8] = rdData;
				ri++;
			end
			if (n > 5000)
				hang("frame");
		end
	endtask

	initial begin
		errors = 0;
		checkCount = 0;
		rst = 1'b1;
		reqValid = 1'b0;
		reqModeThree = 1'b0;
		reqOpcode = 8'h00;
		reqHasAddr = 1'b0;
		reqAddr = 16'h0000;
		reqLen = 8'h00;
		wrData = 8'h00;
		pauseReq = 1'b0;
		protectLow = 1'b0;
		for (int i = 0; i < 8; i++)
			wBuf[i] = pat(i);
		repeat (10) @(posedge sysClk);
		#1;
		rst = 1'b0;
		// top address bit set, write wraps past the last location
		xfer(1'b0, sfr_pkg::OP_WREN, 1'b0, 16'h0000, 8'h00, -1);
		xfer(1'b0, sfr_pkg::OP_WRITE, 1'b1, 16'hfffe, 8'h04, -1);
		check("mode", {7'h00, modeThree}, 8'h00);
		xfer(1'b1, sfr_pkg::OP_READ, 1'b1, 16'h7ffe, 8'h04, -1);
		check("mode", {7'h00, modeThree}, 8'h01);
		for (int i = 0; i < 4; i++) check("rd", rBuf[i], pat(i));
		// fast read: the dummy byte after the address comes back undriven
		xfer(1'b0, sfr_pkg::OP_FSTRD, 1'b1, 16'h0000, 8'h03, -1);
		check("dummy", rBuf[0], 8'hff);
		for (int i = 0; i < 2; i++) check("fast", rBuf[i + 1], pat(i + 2));
		$display("test addressing done");
		wBuf[0] = 8'h8c;
		xfer(1'b0, sfr_pkg::OP_WREN, 1'b0, 16'h0000, 8'h00, -1);
		xfer(1'b0, sfr_pkg::OP_WRSR, 1'b0, 16'h0000, 8'h01, -1);
		check("status", statusView, 8'h8c);
		xfer(1'b0, sfr_pkg::OP_RDSR, 1'b0, 16'h0000, 8'h02, -1);
		for (int i = 0; i < 2; i++) check("rdsr", rBuf[i], 8'h8c);
		wBuf[0] = 8'h00;
		for (int k = 0; k < 2; k++) begin
			protectLow = (k == 0);
			xfer(1'b0, sfr_pkg::OP_WREN, 1'b0, 16'h0000, 8'h00, -1);
			xfer(1'b0, sfr_pkg::OP_WRSR, 1'b0, 16'h0000, 8'h01, -1);
			check("protect", statusView & 8'h8c, (k == 0) ? 8'h8c : 8'h00);
		end
		// write latch: set by one opcode frame, cleared by another
		xfer(1'b0, sfr_pkg::OP_WREN, 1'b0, 16'h0000, 8'h00, -1);
		check("wel", statusView, 8'h02);
		xfer(1'b0, sfr_pkg::OP_WRDI, 1'b0, 16'h0000, 8'h00, -1);
		check("wel", statusView, 8'h00);
		$display("test status done");
		for (int k = 0; k < 2; k++) begin
			xfer(1'b0, (k == 0) ? 8'hb9 : 8'h9f, 1'b1, 16'h7ffe, 8'h02, -1);
			for (int i = 0; i < 2; i++) check("ignored", rBuf[i], 8'hff);
		end
		$display("test unknown done");
		for (int m = 0; m < 2; m++) begin
			xfer(m[0], sfr_pkg::OP_READ, 1'b1, 16'h7ffe, 8'h04, 150);
			for (int i = 0; i < 4; i++) check("paused rd", rBuf[i], pat(i));
		end
		for (int i = 0; i < 8; i++)
			wBuf[i] = ~pat(i);
		xfer(1'b1, sfr_pkg::OP_WREN, 1'b0, 16'h0000, 8'h00, -1);
		xfer(1'b1, sfr_pkg::OP_WRITE, 1'b1, 16'h0010, 8'h03, 90);
		xfer(1'b0, sfr_pkg::OP_READ, 1'b1, 16'h0010, 8'h03, -1);
		for (int i = 0; i < 3; i++) check("paused wr", rBuf[i], ~pat(i));
		$display("test pause done");
		finish_test();
	end
endmodule // spi_fram_slave_front_end_tb_top
